/* File: submsg_element_decoder.sv */
// Purpose: decode sequence/fragment sets, tagged value lists, ipv4 locators
// Assumes: words already aligned to element start; endian flag is per run
// Notes: set bitmap kept internally for membership queries
//
// Contract
// - set holds base plus up to 256 bits
// - bitmap bit one means member, zero absent
// - member needs base<=n<base+count and bit set
// - word d/32, bit 31-d%32, base at msb
// - valid needs base>=1, 0<count<=256
// - consume exactly (count+31)/32 bitmap words
// - wire order base, count, then bitmap
// - fragment set uses same layout, 32-bit base
// - entries start on 4-byte list boundary
// - entry: 16-bit code, 16-bit length, value
// - length is octets to next code, 4-multiple
// - value alignment restarts at first value octet
// - repeated codes each delivered separately
// - code 0 padding, code 1 list end
// - stop at end marker, ignore its length
// - padding skipped by its length
// - primitives aligned to own size in stream
// - compact locator is one udp ipv4 entry
// - endian flag set means little-endian fields
`timescale 1ns/1ps
module submsg_element_decoder (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic start_in,
    input wire elem_pkg::mode_e mode_in,
    input wire logic little_endian_in,
    input wire logic [15:0] avail_bytes_in,
    input wire logic [15:0] known_code_mask_in,
    // word stream from transport
    input wire logic word_valid_in,
    input wire logic [31:0] word_in,
    output logic word_ready_out,
    // decoded elements to protocol logic
    output logic elem_valid_out,
    input wire logic elem_ready_in,
    output elem_pkg::elem_s elem_out,
    // membership query
    input wire logic [63:0] query_num_in,
    output logic query_member_out,
    // status
    output logic busy_out,
    output logic done_out,
    output logic set_valid_out,
    output logic format_error_out,
    output logic [63:0] set_base_number_out,
    output logic [31:0] set_bit_count_out
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_BASE_HI, ST_BASE_LO, ST_COUNT, ST_BITMAP,
        ST_PHDR, ST_PVAL, ST_LOC_KIND, ST_LOC_ADDR, ST_LOC_PORT
    } state_e;

    state_e state_reg;
    logic little_reg;
    logic [63:0] base_reg;
    logic [31:0] count_reg;
    logic [3:0] words_left_reg;
    logic [3:0] word_idx_reg;
    logic [31:0] bitmap_reg [elem_pkg::SET_WORDS];
    logic [15:0] val_left_reg;
    logic [15:0] code_reg;
    logic [15:0] list_pos_reg;
    logic [15:0] avail_reg;
    logic [31:0] addr_reg;
    logic done_reg;
    logic err_reg;
    logic valid_reg;

    // two-entry skid buffer toward protocol logic
    elem_pkg::elem_s buf_reg [2];
    logic [1:0] cnt_reg;
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic push;
    logic pop;
    elem_pkg::elem_s push_data;

    logic [31:0] w;
    logic take;
    logic [15:0] hdr_code;
    logic [15:0] hdr_len;
    logic [3:0] need_words;
    logic hdr_bad;

    // byte swap when sender used little-endian order
    assign w = little_reg ? {word_in[7:0], word_in[15:8],
                             word_in[23:16], word_in[31:24]} : word_in;
    // no input taken unless an output slot is free, so no word is lost
    assign word_ready_out = (state_reg != ST_IDLE) && (cnt_reg != 2'd2);
    assign take = word_valid_in && word_ready_out;
    // a little-endian entry header keeps code in low half after swap
    assign hdr_code = little_reg ? w[15:0] : w[31:16];
    assign hdr_len = little_reg ? w[31:16] : w[15:0];
    // counts above 256 abort first, so four bits hold the result
    assign need_words = 4'((33'(w) + 33'd31) >> 5);
    // a bad header is dropped, so no orphan header reaches the consumer
    assign hdr_bad = (hdr_len[1:0] != 2'b00) ||
                     (list_pos_reg + 16'd4 + hdr_len >= avail_reg);

    always_comb begin
        push = 1'b0;
        push_data = '0;
        if (take) begin
            case (state_reg)
                ST_COUNT: begin
                    push = 1'b1;
                    push_data.kind = elem_pkg::K_SET_HDR;
                    push_data.data = w;
                end
                ST_PHDR: begin
                    // padding and unknown codes produce no output
                    // codes 16 and up pass unless the header is bad; the mask covers the rest
                    if (hdr_code == elem_pkg::END_CODE) begin
                        push = 1'b1;
                        push_data.kind = elem_pkg::K_LIST_END;
                        push_data.code = hdr_code;
                        push_data.last = 1'b1;
                    end else if (hdr_bad) begin
                        push = 1'b0;
                    end else if (hdr_code != elem_pkg::PAD_CODE &&
                                 hdr_code < 16'd16 &&
                                 known_code_mask_in[hdr_code[3:0]]) begin
                        push = 1'b1;
                        push_data.kind = elem_pkg::K_PARAM_HDR;
                        push_data.code = hdr_code;
                        push_data.len = hdr_len;
                    end else if (hdr_code >= 16'd16) begin
                        push = 1'b1;
                        push_data.kind = elem_pkg::K_PARAM_HDR;
                        push_data.code = hdr_code;
                        push_data.len = hdr_len;
                    end
                end
                ST_PVAL: begin
                    // known entry words pass through, each word aligned at 0
                    if (code_reg != elem_pkg::PAD_CODE &&
                        (code_reg >= 16'd16 ||
                         known_code_mask_in[code_reg[3:0]])) begin
                        push = 1'b1;
                        push_data.kind = elem_pkg::K_PARAM_WORD;
                        push_data.code = code_reg;
                        push_data.data = w;
                        push_data.last = (val_left_reg == 16'd4);
                    end
                end
                ST_LOC_PORT: begin
                    // address rides in code and len, one entry per locator
                    push = 1'b1;
                    push_data.kind = elem_pkg::K_LOCATOR;
                    push_data.code = addr_reg[31:16];
                    push_data.len = addr_reg[15:0];
                    push_data.data = w;
                    push_data.last = 1'b1;
                end
                default: push = 1'b0;
            endcase
        end
    end

    // control state machine
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            little_reg <= 1'b0;
            base_reg <= 64'h0000_0000_0000_0000;
            count_reg <= 32'h0000_0000;
            words_left_reg <= 4'h0;
            word_idx_reg <= 4'h0;
            val_left_reg <= 16'h0000;
            code_reg <= 16'h0000;
            list_pos_reg <= 16'h0000;
            avail_reg <= 16'h0000;
            addr_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            if (start_in) begin
                done_reg <= 1'b0;
                err_reg <= 1'b0;
                little_reg <= little_endian_in;
                avail_reg <= avail_bytes_in;
                list_pos_reg <= 16'h0000;
                word_idx_reg <= 4'h0;
                // mode is sampled only here; later changes wait for a new run
                case (mode_in)
                    elem_pkg::MODE_SEQ_SET: state_reg <= ST_BASE_HI;
                    elem_pkg::MODE_FRAG_SET: state_reg <= ST_BASE_LO;
                    elem_pkg::MODE_PLIST: state_reg <= ST_PHDR;
                    elem_pkg::MODE_LOC4: state_reg <= ST_LOC_ADDR;
                    default: state_reg <= ST_IDLE;
                endcase
                if (mode_in == elem_pkg::MODE_FRAG_SET) begin
                    base_reg <= 64'h0000_0000_0000_0000;
                end
            end
        end else if (take) begin
            // words arrive whole, so each 32-bit field sits 4-byte aligned
            list_pos_reg <= list_pos_reg + 16'd4;
            case (state_reg)
                ST_BASE_HI: begin
                    base_reg[63:32] <= w;
                    state_reg <= ST_BASE_LO;
                end
                ST_BASE_LO: begin
                    base_reg[31:0] <= w;
                    state_reg <= ST_COUNT;
                end
                ST_COUNT: begin
                    count_reg <= w;
                    if (w == 32'h0000_0000 || w > 32'(elem_pkg::BITS_MAX)) begin
                        // zero or too-long count: read nothing further, flag it
                        state_reg <= ST_IDLE;
                        done_reg <= 1'b1;
                        err_reg <= 1'b1;
                    end else begin
                        words_left_reg <= need_words;
                        state_reg <= ST_BITMAP;
                    end
                end
                ST_BITMAP: begin
                    word_idx_reg <= word_idx_reg + 4'd1;
                    words_left_reg <= words_left_reg - 4'd1;
                    // last pertinent word ends the set; no trailing word read
                    if (words_left_reg == 4'd1) begin
                        state_reg <= ST_IDLE;
                        done_reg <= 1'b1;
                    end
                end
                ST_PHDR: begin
                    code_reg <= hdr_code;
                    val_left_reg <= hdr_len;
                    if (hdr_code == elem_pkg::END_CODE) begin
                        state_reg <= ST_IDLE;
                        done_reg <= 1'b1;
                    end else if (hdr_bad) begin
                        state_reg <= ST_IDLE;
                        done_reg <= 1'b1;
                        err_reg <= 1'b1;
                    // zero length: the next word is already the next header
                    end else if (hdr_len != 16'h0000) begin
                        state_reg <= ST_PVAL;
                    end
                end
                ST_PVAL: begin
                    val_left_reg <= val_left_reg - 16'd4;
                    if (val_left_reg == 16'd4) begin
                        state_reg <= ST_PHDR;
                    end
                end
                ST_LOC_ADDR: begin
                    addr_reg <= w;
                    state_reg <= ST_LOC_PORT;
                end
                ST_LOC_PORT: begin
                    state_reg <= ST_IDLE;
                    done_reg <= 1'b1;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // bitmap store, one entry per word, msb = base
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < elem_pkg::SET_WORDS; i++) begin
                bitmap_reg[i] <= 32'h0000_0000;
            end
        end else if (state_reg == ST_IDLE && start_in) begin
            // cleared on start so a short set shows no stale bits
            for (int i = 0; i < elem_pkg::SET_WORDS; i++) begin
                bitmap_reg[i] <= 32'h0000_0000;
            end
        end else if (take && state_reg == ST_BITMAP) begin
            bitmap_reg[word_idx_reg[2:0]] <= w;
        end
    end

    // set is valid once fully read with legal base and count
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            valid_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && start_in) begin
            valid_reg <= 1'b0;
        end else if (take && state_reg == ST_BITMAP &&
                     words_left_reg == 4'd1) begin
            valid_reg <= (base_reg != 64'h0000_0000_0000_0000);
        end
    end

    // membership test; frag bases are zero-extended, one compare serves both
    logic [63:0] offset_from_base;
    logic [31:0] sel_word;
    logic in_range;
    assign offset_from_base = query_num_in - base_reg;
    assign in_range = (query_num_in >= base_reg) &&
                      (offset_from_base < {32'h0000_0000, count_reg});
    assign sel_word = bitmap_reg[offset_from_base[7:5]];
    assign query_member_out = valid_reg && in_range &&
                              sel_word[5'd31 - offset_from_base[4:0]];

    // output buffer
    assign pop = elem_valid_out && elem_ready_in;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_reg <= 2'd0;
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            buf_reg[0] <= '0;
            buf_reg[1] <= '0;
        end else begin
            if (push) begin
                buf_reg[wr_ptr_reg] <= push_data;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            // push and pop together leave the count as it is
            cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
        end
    end
    assign elem_valid_out = (cnt_reg != 2'd0);
    // data comes from buffer flops, never straight from the input
    assign elem_out = buf_reg[rd_ptr_reg];

    assign busy_out = (state_reg != ST_IDLE);
    assign done_out = done_reg;
    assign format_error_out = err_reg;
    assign set_valid_out = valid_reg;
    assign set_base_number_out = base_reg;
    assign set_bit_count_out = count_reg;
endmodule

/* File: elem_pkg.sv */
// Purpose: shared constants and carriers for the submessage element decoder
// Assumes: 32-bit word stream input, one word per beat
// Notes: sequence numbers are 64 bits (high word first)
package elem_pkg;
    localparam int WORD_W = 32;
    localparam int SET_MAX_BITS = 256;
    localparam int SET_WORDS = 8;
    localparam logic [15:0] PAD_CODE = 16'h0000;
    localparam logic [15:0] END_CODE = 16'h0001;
    localparam logic [31:0] IPV4_UDP_KIND = 32'h0000_0001;
    localparam logic [8:0] BITS_MAX = 9'h100;

    typedef enum logic [2:0] {
        MODE_SEQ_SET,
        MODE_FRAG_SET,
        MODE_PLIST,
        MODE_LOC4
    } mode_e;

    // decoded element record handed to protocol logic
    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] code;
        logic [15:0] len;
        logic [31:0] data;
        logic last;
    } elem_s;

    localparam logic [2:0] K_SET_HDR = 3'h0;
    localparam logic [2:0] K_PARAM_HDR = 3'h1;
    localparam logic [2:0] K_PARAM_WORD = 3'h2;
    localparam logic [2:0] K_LOCATOR = 3'h3;
    localparam logic [2:0] K_LIST_END = 3'h4;
endpackage

/* File: submsg_element_decoder_chk.sv */
// Purpose: port checks for submsg_element_decoder
// Assumes: one clock, sync active-high reset
// Notes: bound into every decoder instance
`timescale 1ns/1ps
module submsg_element_decoder_chk (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // watched ports
    input wire logic start_in,
    input wire logic word_ready_out,
    input wire logic elem_valid_out,
    input wire logic elem_ready_in,
    input wire elem_pkg::elem_s elem_out,
    input wire logic [63:0] query_num_in,
    input wire logic query_member_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic set_valid_out,
    input wire logic format_error_out,
    input wire logic [63:0] set_base_number_out,
    input wire logic [31:0] set_bit_count_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    rst_clear_a: assert property ($fell(srst_in) |-> !busy_out && !done_out
        && !word_ready_out && !elem_valid_out && !set_valid_out)
        else $error("outputs not cleared by reset");
    idle_refuse_a: assert property (!busy_out |-> !word_ready_out)
        else $error("word ready while idle");
    start_run_a: assert property (start_in && !busy_out |=>
        busy_out && !done_out && !format_error_out)
        else $error("start did not open a run");
    run_end_a: assert property ($fell(busy_out) |-> done_out
        || format_error_out)
        else $error("run ended without status");
    done_hold_a: assert property (done_out && !start_in |=> done_out)
        else $error("done dropped early");
    elem_hold_a: assert property (elem_valid_out && !elem_ready_in |=>
        elem_valid_out && $stable(elem_out))
        else $error("element lost or changed");
    member_range_a: assert property (query_member_out |->
        query_num_in >= set_base_number_out && query_num_in
        - set_base_number_out < 64'(set_bit_count_out))
        else $error("member outside set range");
    set_ok_a: assert property (set_valid_out |->
        set_base_number_out != 64'h0 && set_bit_count_out != 32'h0
        && set_bit_count_out <= 32'h0000_0100)
        else $error("invalid set flagged valid");
    cover property (elem_valid_out && !elem_ready_in ##1 !word_ready_out);
    cover property (query_member_out);
    cover property ($rose(format_error_out));
endmodule
bind submsg_element_decoder submsg_element_decoder_chk u_chk (.*);

/* File: word_source.sv */
// Purpose: transport-side word source for the decoder
// Assumes: bench queues words in wire order
// Notes: slow mode idles every other cycle; idle data toggles
`timescale 1ns/1ps
module word_source (
    // clock, reset and pacing
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic slow_in,
    // stream to decoder
    input wire logic ready_in,
    output logic valid_out,
    output logic [31:0] word_out
);
    logic [31:0] q[$];
    logic taken;
    logic gap = 1'b0;
    initial begin
        valid_out = 1'b0;
        word_out = 32'h0000_0000;
    end
    // a word stands until taken, in queue order
    always @(posedge clk_in) begin
        taken = valid_out && ready_in;
        #1;
        if (taken) begin
            void'(q.pop_front());
        end
        if (taken || !valid_out) begin
            gap = slow_in && !gap;
            valid_out = q.size() > 0 && !gap && !srst_in;
            // stale data is the last word inverted, inverting again on each further idle cycle
            word_out = valid_out ? q[0] : ~word_out;
        end
    end
endmodule

/* File: submsg_element_decoder_tb_top.sv */
// Purpose: self-checking bench for submsg_element_decoder
// Assumes: inputs move 1 ns after the rising edge
// Notes: word_source stands in for the transport
`timescale 1ns/1ps
module submsg_element_decoder_tb_top;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic start = 1'b0;
    logic le = 1'b0;
    logic slow = 1'b0;
    logic e_ready = 1'b1;
    logic w_valid, w_ready, e_valid, busy, done, s_valid, f_err, member;
    elem_pkg::mode_e mode = elem_pkg::MODE_SEQ_SET;
    logic [15:0] avail = 16'h0000;
    logic [31:0] word, count;
    logic [63:0] query = 64'h0000, base;
    elem_pkg::elem_s e_out, got[$];
    int error_cnt = 0;
    int checks_done = 0;
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    word_source src (.clk_in(clk_in), .srst_in(srst_in), .slow_in(slow),
        .ready_in(w_ready), .valid_out(w_valid), .word_out(word));
    // code 3 known, code 5 left unknown
    submsg_element_decoder DUT (.clk_in(clk_in), .srst_in(srst_in),
        .start_in(start), .mode_in(mode), .little_endian_in(le),
        .avail_bytes_in(avail), .known_code_mask_in(16'h0008),
        .word_valid_in(w_valid), .word_in(word), .word_ready_out(w_ready),
        .elem_valid_out(e_valid), .elem_ready_in(e_ready), .elem_out(e_out),
        .query_num_in(query), .query_member_out(member), .busy_out(busy),
        .done_out(done), .set_valid_out(s_valid), .format_error_out(f_err),
        .set_base_number_out(base), .set_bit_count_out(count));
    always @(posedge clk_in) begin
        if (e_valid && e_ready) begin
            got.push_back(e_out);
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [63:0] exp, logic [63:0] seen);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", what, exp, seen);
        end
    endtask
    task automatic go(elem_pkg::mode_e m, logic [15:0] av);
        int n;
        got.delete();
        mode = m;
        avail = av;
        start = 1'b1;
        @(posedge clk_in);
        #1;
        start = 1'b0;
        for (n = 0; n < 300 && done !== 1'b1 && f_err !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        if (n == 300) begin
            chk("run end", 64'h1, 64'h0);
            tally_and_finish();
        end
        repeat (3) @(posedge clk_in);
        #1;
        chk("busy", 64'h0, 64'(busy));
    endtask
    task automatic take(logic [2:0] k, logic [31:0] a, logic [31:0] d);
        elem_pkg::elem_s e;
        e = 'x;
        if (got.size() > 0) begin
            e = got.pop_front();
        end
        chk("kind", 64'(k), 64'(e.kind));
        if (k == elem_pkg::K_PARAM_HDR || k == elem_pkg::K_LOCATOR) begin
            chk("code len", 64'(a), 64'({e.code, e.len}));
        end
        if (k == elem_pkg::K_PARAM_WORD || k == elem_pkg::K_LOCATOR ||
            k == elem_pkg::K_SET_HDR) begin
            chk("data", 64'(d), 64'(e.data));
        end
        if (k == elem_pkg::K_LIST_END || k == elem_pkg::K_LOCATOR) begin
            chk("last", 64'h1, 64'(e.last));
        end
    endtask
    task automatic mem(logic [63:0] n, logic exp);
        query = n;
        @(posedge clk_in);
        #1;
        chk("member", 64'(exp), 64'(member));
    endtask
    task automatic seq_set();
        src.q = '{32'h0, 32'h04D2, 32'h000C, 32'h3008_0000};
        go(elem_pkg::MODE_SEQ_SET, 16'h0000);
        take(elem_pkg::K_SET_HDR, 32'h0, 32'h000C);
        chk("valid", 64'h1, 64'(s_valid));
        chk("base", 64'h04D2, base);
        chk("count", 64'h000C, 64'(count));
        mem(64'h04D1, 1'b0);
        mem(64'h04D2, 1'b0);
        mem(64'h04D4, 1'b1);
        mem(64'h04DD, 1'b0);
        mem(64'h04DE, 1'b0);
    endtask
    task automatic frag_sets();
        slow = 1'b1;
        src.q = '{32'h0005, 32'h0021, 32'h0, 32'h8000_0000};
        go(elem_pkg::MODE_FRAG_SET, 16'h0000);
        slow = 1'b0;
        chk("count", 64'h0021, 64'(count));
        mem(64'h0025, 1'b1);
        mem(64'h0026, 1'b0);
        src.q = '{32'h0, 32'h0001, 32'h8000_0000};
        go(elem_pkg::MODE_FRAG_SET, 16'h0000);
        chk("base zero", 64'h0, 64'(s_valid));
        src.q = '{32'h0009, 32'h0101};
        go(elem_pkg::MODE_FRAG_SET, 16'h0000);
        chk("oversize", 64'h1, 64'(f_err));
        src.q = '{32'h0, 32'h0007, 32'h0};
        go(elem_pkg::MODE_SEQ_SET, 16'h0000);
        chk("count zero", 64'h1, 64'(f_err));
    endtask
    task automatic plist_stall();
        // pad, code 3 twice, unknown 5, end with junk length
        src.q = '{32'h0004, 32'h1111, 32'h0003_0004, 32'hA5A5_0001,
            32'h0003_0004, 32'hA5A5_0002, 32'h0005_0008, 32'h0,
            32'h0, 32'h0001_0FF0};
        e_ready = 1'b0;
        fork
            go(elem_pkg::MODE_PLIST, 16'h0028);
            begin
                repeat (20) @(posedge clk_in);
                #1;
                chk("ready full", 64'h0, 64'(w_ready));
                e_ready = 1'b1;
            end
        join
        chk("error", 64'h0, 64'(f_err));
        take(elem_pkg::K_PARAM_HDR, 32'h0003_0004, 32'h0);
        take(elem_pkg::K_PARAM_WORD, 32'h0, 32'hA5A5_0001);
        take(elem_pkg::K_PARAM_HDR, 32'h0003_0004, 32'h0);
        take(elem_pkg::K_PARAM_WORD, 32'h0, 32'hA5A5_0002);
        take(elem_pkg::K_LIST_END, 32'h0, 32'h0);
    endtask
    task automatic plist_other();
        le = 1'b1;
        src.q = '{32'h0300_0400, 32'h1122_3344, 32'h0100_0000};
        go(elem_pkg::MODE_PLIST, 16'h000C);
        le = 1'b0;
        take(elem_pkg::K_PARAM_HDR, 32'h0003_0004, 32'h0);
        take(elem_pkg::K_PARAM_WORD, 32'h0, 32'h4433_2211);
        // known code with a bad length: flagged, header not delivered
        src.q = '{32'h0003_0006};
        go(elem_pkg::MODE_PLIST, 16'h0010);
        chk("bad len", 64'h1, 64'(f_err));
        chk("dropped", 64'h0, 64'(got.size()));
        // code above the mask range, empty value, then end
        src.q = '{32'h0040_0000, 32'h0001_0000};
        go(elem_pkg::MODE_PLIST, 16'h0008);
        take(elem_pkg::K_PARAM_HDR, 32'h0040_0000, 32'h0);
        take(elem_pkg::K_LIST_END, 32'h0, 32'h0);
        src.q = '{32'hC0A8_0001, 32'h1CE8};
        go(elem_pkg::MODE_LOC4, 16'h0000);
        take(elem_pkg::K_LOCATOR, 32'hC0A8_0001, 32'h1CE8);
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        #1;
        srst_in = 1'b0;
        seq_set();
        frag_sets();
        plist_stall();
        plist_other();
        tally_and_finish();
    end
endmodule
